// *** rtl/macsec_ctx_pkg.sv ***
package macsec_ctx_pkg;

   // ***************************************************************
   // bus map
   // ***************************************************************
   localparam int              AVS_ADDR_W        = 11;
   localparam logic [10:0]     REG_CTX_CTRL      = 11'h000;
   localparam logic [10:0]     REG_COUNT_LIMIT   = 11'h004;
   localparam logic [10:0]     REG_IRQ_STAT      = 11'h008;
   localparam logic [10:0]     REG_FLOW_CTRL     = 11'h00c;
   localparam int              REC_BASE_BIT      = 10;
   localparam int              REC_WORDS         = 24;
   localparam logic [4:0]      FETCH_WORDS_SMALL = 5'h14;
   localparam logic [4:0]      FETCH_WORDS_LARGE = 5'h18;
   localparam int              CTX_SIZE_BIT      = 0;
   localparam int              IRQ_THRESH_BIT    = 4;
   localparam int              IRQ_ROLL_BIT      = 5;
   localparam logic [31:0]     CTX_CTRL_RST      = 32'h0000_0000;
   localparam logic [31:0]     COUNT_LIMIT_RST   = 32'hffff_ffff;
   localparam logic [31:0]     FLOW_CTRL_RST     = 32'h0000_0000;

   // ***************************************************************
   // flow types, two bits per SA in the flow register
   // ***************************************************************
   localparam logic [1:0]      FLOW_BYPASS       = 2'h0;
   localparam logic [1:0]      FLOW_DROP         = 2'h1;
   localparam logic [1:0]      FLOW_MACSEC       = 2'h2;

   // ***************************************************************
   // context control word fields and record word indexes
   // ***************************************************************
   localparam logic [3:0]      PKT_EGRESS        = 4'h6;
   localparam logic [3:0]      PKT_INGRESS       = 4'hf;
   localparam int              CW_UPDATE_SEQ     = 13;
   localparam int              CW_CIPHER_LSB     = 17;
   localparam logic [2:0]      CIPHER_AES128     = 3'h5;
   localparam logic [2:0]      CIPHER_AES256     = 3'h7;
   localparam int              CW_AN_LSB         = 26;
   localparam logic [4:0]      W_CTRL            = 5'h00;
   localparam logic [4:0]      W_KEY0            = 5'h02;
   localparam logic [4:0]      W_HASH_128        = 5'h06;
   localparam logic [4:0]      W_HASH_256        = 5'h0a;
   localparam logic [4:0]      W_SEQ_128         = 5'h0a;
   localparam logic [4:0]      W_SEQ_256         = 5'h0e;
   localparam logic [31:0]     SEQ_MAX           = 32'hffff_ffff;

   // ***************************************************************
   // engine states and carriers
   // ***************************************************************
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01,
      ST_CHECK = 2'b10,
      ST_DONE  = 2'b11
   } engine_state_e;

   typedef struct packed {
      logic [7:0]  sa;
      logic [31:0] rx_pn;
   } pkt_req_s;

   typedef struct packed {
      logic        processed;
      logic        bypassed;
      logic        dropped;
      logic        ctx_invalid;
      logic        egress;
      logic        seq_err;
      logic        replay_fail;
      logic [1:0]  association_number;
      logic [31:0] pn;
      logic [63:0] sci;
   } pkt_rsp_s;

endpackage

// *** rtl/seq_window_check.sv ***
`timescale 1ns/1ps
module seq_window_check
   import macsec_ctx_pkg::*;
(
   // context view
   input  wire logic        egress_in,
   input  wire logic        update_en_in,
   input  wire logic [31:0] ctx_seq_in,
   input  wire logic [31:0] window_in,
   input  wire logic [31:0] limit_in,
   // received packet number
   input  wire logic [31:0] rx_pn_in,
   // verdict
   output logic      [31:0] new_seq_out,
   output logic             wr_out,
   output logic             seq_err_out,
   output logic             replay_fail_out,
   output logic             thresh_out,
   output logic             roll_out
);

   logic [31:0] lower;

   // one verdict per packet, purely combinational
   always_comb begin
      new_seq_out     = ctx_seq_in + 32'h1;
      wr_out          = 1'b0;
      seq_err_out     = 1'b0;
      replay_fail_out = 1'b0;
      thresh_out      = 1'b0;
      roll_out        = 1'b0;
      // window above the context value leaves no lower bound
      lower           = (window_in >= ctx_seq_in) ? 32'h0 : ctx_seq_in - window_in;
      if (egress_in) begin
         if (ctx_seq_in == SEQ_MAX) begin
            // stuck on purpose: every later packet errors too
            seq_err_out = 1'b1;
            roll_out    = 1'b1;
         end else begin
            wr_out     = update_en_in;
            thresh_out = (new_seq_out > limit_in) && (ctx_seq_in <= limit_in);
         end
      end else if (rx_pn_in >= ctx_seq_in) begin
         new_seq_out = rx_pn_in + 32'h1;
         wr_out      = update_en_in;
      end else if (rx_pn_in < lower || rx_pn_in == 32'h0) begin
         replay_fail_out = 1'b1;
      end
   end

endmodule

// *** rtl/macsec_sa_context_seq.sv ***
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module macsec_sa_context_seq
   import macsec_ctx_pkg::*;
#(
   parameter int NUM_SA = 4
)(
   // clock and reset
   input  wire logic                  CLK_IN,
   input  wire logic                  SYS_RST_IN,
   // avalon-mm slave
   input  wire logic [AVS_ADDR_W-1:0] AVS_ADDRESS_IN,
   input  wire logic                  AVS_READ_IN,
   input  wire logic                  AVS_WRITE_IN,
   input  wire logic [31:0]           AVS_WRITEDATA_IN,
   input  wire logic [3:0]            AVS_BYTEENABLE_IN,
   output logic      [31:0]           AVS_READDATA_OUT,
   output logic                       AVS_WAITREQUEST_OUT,
   // packet request
   input  wire logic                  REQ_VALID_IN,
   input  wire pkt_req_s              REQ_IN,
   output logic                       REQ_READY_OUT,
   // packet result
   output logic                       RSP_VALID_OUT,
   output pkt_rsp_s                   RSP_OUT,
   output logic      [255:0]          KEY_OUT,
   output logic      [127:0]          HASH_KEY_OUT
);

   localparam int SA_W = (NUM_SA > 1) ? $clog2(NUM_SA) : 1;

   // ***************************************************************
   // decode helpers
   // ***************************************************************
   function automatic logic rec_hit(input logic [AVS_ADDR_W-1:0] a);
      rec_hit = a[REC_BASE_BIT] && (int'(a[9:7]) < NUM_SA) && (int'(a[6:2]) < REC_WORDS);
   endfunction

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      be_merge = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            be_merge[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
   endfunction

   // ***************************************************************
   // bus slave and registers
   // ***************************************************************
   logic        ack_ff, nxt_ack;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [31:0] ctx_ctrl_ff, nxt_ctx_ctrl;
   logic [31:0] limit_ff, nxt_limit;
   logic [31:0] irq_ff, nxt_irq;
   logic [31:0] flow_ff, nxt_flow;
   logic [31:0] rec_ff  [NUM_SA][REC_WORDS];
   logic [31:0] nxt_rec [NUM_SA][REC_WORDS];
   logic        wr_commit;
   logic [SA_W-1:0] bus_sa;
   logic [4:0]  bus_word;

   // engine side signals used by the register group
   engine_state_e   state_ff, nxt_state;
   logic [SA_W-1:0] sa_ff, nxt_sa;
   logic            wb_en;
   logic [4:0]      seq_idx;
   logic [31:0]     new_seq;
   logic            ck_thresh, ck_roll, ck_valid;

   // one wait state per access: read data is ready when waitrequest drops
   assign AVS_WAITREQUEST_OUT = (AVS_READ_IN || AVS_WRITE_IN) && !ack_ff;
   assign AVS_READDATA_OUT    = rdata_ff;
   assign wr_commit           = AVS_WRITE_IN && ack_ff;
   assign bus_sa              = AVS_ADDRESS_IN[7 +: SA_W];
   assign bus_word            = AVS_ADDRESS_IN[6:2];

   // register and record next values; hardware sets beat software clears
   always_comb begin
      nxt_ack      = (AVS_READ_IN || AVS_WRITE_IN) && !ack_ff;
      nxt_rdata    = rdata_ff;
      nxt_ctx_ctrl = ctx_ctrl_ff;
      nxt_limit    = limit_ff;
      nxt_irq      = irq_ff;
      nxt_flow     = flow_ff;
      nxt_rec      = rec_ff;
      if (AVS_READ_IN && !ack_ff) begin
         nxt_rdata = 32'h0;
         case (AVS_ADDRESS_IN)
            REG_CTX_CTRL:    nxt_rdata = ctx_ctrl_ff;
            REG_COUNT_LIMIT: nxt_rdata = limit_ff;
            REG_IRQ_STAT:    nxt_rdata = irq_ff;
            REG_FLOW_CTRL:   nxt_rdata = flow_ff;
            default: begin
               if (rec_hit(AVS_ADDRESS_IN)) begin
                  nxt_rdata = rec_ff[bus_sa][bus_word];
               end
            end
         endcase
      end
      if (wr_commit) begin
         case (AVS_ADDRESS_IN)
            REG_CTX_CTRL:    nxt_ctx_ctrl = be_merge(ctx_ctrl_ff, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
            REG_COUNT_LIMIT: nxt_limit    = be_merge(limit_ff, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
            REG_IRQ_STAT:    nxt_irq      = irq_ff & ~be_merge(32'h0, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
            REG_FLOW_CTRL:   nxt_flow     = be_merge(flow_ff, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
            default: begin
               if (rec_hit(AVS_ADDRESS_IN)) begin
                  nxt_rec[bus_sa][bus_word] = be_merge(rec_ff[bus_sa][bus_word], AVS_WRITEDATA_IN,
                                                       AVS_BYTEENABLE_IN);
               end
            end
         endcase
      end
      // write-back touches the sequence word and nothing else
      if (wb_en) begin
         nxt_rec[sa_ff][seq_idx] = new_seq;
      end
      if (state_ff == ST_CHECK && ck_valid && ck_thresh) begin
         nxt_irq[IRQ_THRESH_BIT] = 1'b1;
      end
      if (state_ff == ST_CHECK && ck_valid && ck_roll) begin
         nxt_irq[IRQ_ROLL_BIT] = 1'b1;
      end
      // only the two event bits exist
      nxt_irq = nxt_irq & ((32'h1 << IRQ_THRESH_BIT) | (32'h1 << IRQ_ROLL_BIT));
   end

   // record storage has no reset: software loads it before use
   always_ff @(posedge CLK_IN) begin
      rec_ff <= nxt_rec;
      if (SYS_RST_IN) begin
         ack_ff      <= 1'b0;
         rdata_ff    <= 32'h0;
         ctx_ctrl_ff <= CTX_CTRL_RST;
         limit_ff    <= COUNT_LIMIT_RST;
         irq_ff      <= 32'h0;
         flow_ff     <= FLOW_CTRL_RST;
      end else begin
         ack_ff      <= nxt_ack;
         rdata_ff    <= nxt_rdata;
         ctx_ctrl_ff <= nxt_ctx_ctrl;
         limit_ff    <= nxt_limit;
         irq_ff      <= nxt_irq;
         flow_ff     <= nxt_flow;
      end
   end

   // ***************************************************************
   // context engine
   // ***************************************************************
   logic [31:0]  ctx_ff [REC_WORDS];
   logic [31:0]  nxt_ctx [REC_WORDS];
   logic [4:0]   fcnt_ff, nxt_fcnt;
   logic [4:0]   flen_ff, nxt_flen;
   logic [31:0]  rx_ff, nxt_rx;
   pkt_rsp_s     rsp_ff, nxt_rsp;
   logic [255:0] key_ff, nxt_key;
   logic [127:0] hash_ff, nxt_hash;
   logic [31:0]  ctrl;
   logic         egress, is256;
   logic [4:0]   hash_idx, win_idx, iv_idx;
   logic [1:0]   req_flow;
   logic         req_sa_ok;
   logic         ck_wr, ck_seq_err, ck_replay;

   assign ctrl      = ctx_ff[W_CTRL];
   // reserved control bits are never decoded, so stray values are harmless
   assign egress    = ctrl[3:0] == PKT_EGRESS;
   assign is256     = ctrl[CW_CIPHER_LSB +: 3] == CIPHER_AES256;
   // unknown type or cipher: context is refused, no write-back
   assign ck_valid  = (egress || ctrl[3:0] == PKT_INGRESS) &&
                      (is256 || ctrl[CW_CIPHER_LSB +: 3] == CIPHER_AES128);
   assign seq_idx   = is256 ? W_SEQ_256 : W_SEQ_128;
   assign hash_idx  = is256 ? W_HASH_256 : W_HASH_128;
   assign win_idx   = seq_idx + 5'h1;
   assign iv_idx    = egress ? seq_idx + 5'h1 : seq_idx + 5'h2;
   assign req_sa_ok = int'(REQ_IN.sa) < NUM_SA;
   assign req_flow  = flow_ff[2*REQ_IN.sa[3:0] +: 2];
   assign wb_en     = state_ff == ST_CHECK && ck_valid && ck_wr;

   assign REQ_READY_OUT = state_ff == ST_IDLE;
   assign RSP_VALID_OUT = state_ff == ST_DONE;
   assign RSP_OUT       = rsp_ff;
   assign KEY_OUT       = key_ff;
   assign HASH_KEY_OUT  = hash_ff;

   seq_window_check u_check (
      .egress_in       (egress),
      .update_en_in    (ctrl[CW_UPDATE_SEQ]),
      .ctx_seq_in      (ctx_ff[seq_idx]),
      .window_in       (ctx_ff[win_idx]),
      .limit_in        (limit_ff),
      .rx_pn_in        (rx_ff),
      .new_seq_out     (new_seq),
      .wr_out          (ck_wr),
      .seq_err_out     (ck_seq_err),
      .replay_fail_out (ck_replay),
      .thresh_out      (ck_thresh),
      .roll_out        (ck_roll)
   );

   // request accept, word fetch, verdict, result
   always_comb begin
      nxt_state = state_ff;
      nxt_sa    = sa_ff;
      nxt_fcnt  = fcnt_ff;
      nxt_flen  = flen_ff;
      nxt_rx    = rx_ff;
      nxt_ctx   = ctx_ff;
      nxt_rsp   = rsp_ff;
      nxt_key   = key_ff;
      nxt_hash  = hash_ff;
      case (state_ff)
         ST_IDLE: begin
            if (REQ_VALID_IN) begin
               nxt_sa   = REQ_IN.sa[SA_W-1:0];
               nxt_rx   = REQ_IN.rx_pn;
               nxt_fcnt = 5'h0;
               nxt_rsp  = '0;
               // fetch length latched per packet so a mid-packet change is harmless
               nxt_flen = ctx_ctrl_ff[CTX_SIZE_BIT] ? FETCH_WORDS_LARGE : FETCH_WORDS_SMALL;
               if (req_sa_ok && req_flow == FLOW_MACSEC) begin
                  nxt_state = ST_FETCH;
               end else begin
                  // no record is touched for these flows
                  nxt_rsp.bypassed = req_sa_ok && req_flow == FLOW_BYPASS;
                  nxt_rsp.dropped  = !nxt_rsp.bypassed;
                  nxt_state        = ST_DONE;
               end
            end
         end
         ST_FETCH: begin
            nxt_ctx[fcnt_ff] = rec_ff[sa_ff][fcnt_ff];
            nxt_fcnt         = fcnt_ff + 5'h1;
            if (fcnt_ff == flen_ff - 5'h1) begin
               nxt_state = ST_CHECK;
            end
         end
         ST_CHECK: begin
            nxt_rsp.processed   = ck_valid;
            nxt_rsp.ctx_invalid = !ck_valid;
            nxt_rsp.egress      = egress;
            nxt_rsp.seq_err     = ck_valid && ck_seq_err;
            nxt_rsp.replay_fail = ck_valid && ck_replay;
            nxt_rsp.association_number = egress ? ctrl[CW_AN_LSB +: 2] : 2'h0;
            // egress inserts the stored value plus one
            nxt_rsp.pn  = egress ? ctx_ff[seq_idx] + 32'h1 : rx_ff;
            nxt_rsp.sci = {ctx_ff[iv_idx + 5'h1], ctx_ff[iv_idx]};
            for (int i = 0; i < 8; i++) begin
               nxt_key[i*32 +: 32] = (i < 4 || is256) ? ctx_ff[W_KEY0 + 5'(i)] : 32'h0;
            end
            for (int i = 0; i < 4; i++) begin
               nxt_hash[i*32 +: 32] = ctx_ff[hash_idx + 5'(i)];
            end
            nxt_state = ST_DONE;
         end
         ST_DONE: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // engine registers
   always_ff @(posedge CLK_IN) begin
      ctx_ff  <= nxt_ctx;
      rx_ff   <= nxt_rx;
      key_ff  <= SYS_RST_IN ? 256'h0 : nxt_key;
      hash_ff <= SYS_RST_IN ? 128'h0 : nxt_hash;
      if (SYS_RST_IN) begin
         state_ff <= ST_IDLE;
         sa_ff    <= '0;
         fcnt_ff  <= 5'h0;
         flen_ff  <= FETCH_WORDS_SMALL;
         rsp_ff   <= '0;
      end else begin
         state_ff <= nxt_state;
         sa_ff    <= nxt_sa;
         fcnt_ff  <= nxt_fcnt;
         flen_ff  <= nxt_flen;
         rsp_ff   <= nxt_rsp;
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   logic [5:0] fetch_cyc_ff;

   // counts cycles spent fetching, checked against the latched length
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN || state_ff == ST_IDLE) begin
         fetch_cyc_ff <= 6'h0;
      end else if (state_ff == ST_FETCH) begin
         fetch_cyc_ff <= fetch_cyc_ff + 6'h1;
      end
   end

   property p_fetch_len;
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (state_ff == ST_CHECK && $past(state_ff) == ST_FETCH) |-> fetch_cyc_ff == {1'b0, flen_ff};
   endproperty
   a_fetch_len: assert property (p_fetch_len) else $error("fetch length wrong");

   property p_flow_skip;
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (state_ff == ST_IDLE && REQ_VALID_IN && !(req_sa_ok && req_flow == FLOW_MACSEC))
      |=> state_ff == ST_DONE ##0 (rsp_ff.bypassed || rsp_ff.dropped) ##0 !rsp_ff.processed;
   endproperty
   a_flow_skip: assert property (p_flow_skip) else $error("non-secure flow fetched");

   property p_ctrl_kept;
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (state_ff == ST_CHECK && !wr_commit) |=> rec_ff[sa_ff][W_CTRL] == $past(rec_ff[sa_ff][W_CTRL]);
   endproperty
   a_ctrl_kept: assert property (p_ctrl_kept) else $error("control word altered");

   property p_invalid;
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (state_ff == ST_CHECK && !ck_valid) |-> !wb_en ##1 (rsp_ff.ctx_invalid && RSP_VALID_OUT);
   endproperty
   a_invalid: assert property (p_invalid) else $error("invalid context used");

   property p_egress_inc;
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (state_ff == ST_CHECK && ck_valid && egress && ctrl[CW_UPDATE_SEQ] && ctx_ff[seq_idx] != SEQ_MAX)
      |=> rec_ff[sa_ff][$past(seq_idx)] == $past(ctx_ff[seq_idx]) + 32'h1 &&
          rsp_ff.pn == rec_ff[sa_ff][$past(seq_idx)];
   endproperty
   a_egress_inc: assert property (p_egress_inc) else $error("egress increment wrong");

   property p_roll;
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (state_ff == ST_CHECK && ck_valid && egress && ctx_ff[seq_idx] == SEQ_MAX)
      |-> !wb_en ##1 (rsp_ff.seq_err && irq_ff[IRQ_ROLL_BIT]);
   endproperty
   a_roll: assert property (p_roll) else $error("roll-over not flagged");

   property p_replay;
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (state_ff == ST_CHECK && ck_valid && !egress && rx_ff < ctx_ff[seq_idx] &&
       ctx_ff[win_idx] < ctx_ff[seq_idx] && rx_ff < ctx_ff[seq_idx] - ctx_ff[win_idx])
      |-> !wb_en ##1 rsp_ff.replay_fail;
   endproperty
   a_replay: assert property (p_replay) else $error("stale number accepted");

   property p_ingress_up;
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (state_ff == ST_CHECK && ck_valid && !egress && ctrl[CW_UPDATE_SEQ] && rx_ff >= ctx_ff[seq_idx])
      |=> rec_ff[sa_ff][$past(seq_idx)] == $past(rx_ff) + 32'h1 && !rsp_ff.replay_fail;
   endproperty
   a_ingress_up: assert property (p_ingress_up) else $error("ingress update wrong");

   property p_an;
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (RSP_VALID_OUT && rsp_ff.processed && rsp_ff.egress) |-> rsp_ff.association_number == ctrl[CW_AN_LSB +: 2];
   endproperty
   a_an: assert property (p_an) else $error("association number wrong");

   property p_thresh;
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (state_ff == ST_CHECK && ck_valid && egress && ctx_ff[seq_idx] == limit_ff && limit_ff != SEQ_MAX)
      |=> irq_ff[IRQ_THRESH_BIT];
   endproperty
   a_thresh: assert property (p_thresh) else $error("threshold not flagged");

   property p_bus_wait;
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      ((AVS_READ_IN || AVS_WRITE_IN) && !ack_ff) |-> AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT;
   endproperty
   a_bus_wait: assert property (p_bus_wait) else $error("bus answer late");

   c_egress_ok:  cover property (@(posedge CLK_IN) RSP_VALID_OUT && rsp_ff.processed && rsp_ff.egress &&
                                 !rsp_ff.seq_err);
   c_roll:       cover property (@(posedge CLK_IN) RSP_VALID_OUT && rsp_ff.seq_err);
   c_replay:     cover property (@(posedge CLK_IN) RSP_VALID_OUT && rsp_ff.replay_fail);
   c_bypass:     cover property (@(posedge CLK_IN) RSP_VALID_OUT && rsp_ff.bypassed);

endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
   import macsec_ctx_pkg::*;
   // ***********************
   // stimulus and wiring
   // ***********************
   logic           clk = 0, rst = 1, rd = 0, wr = 0, vld = 0, rdy, wq, rv;
   logic [10:0]    adr = 0;
   logic [31:0]    wd = 0, rdat, q;
   logic [255:0]   key;
   logic [127:0]   hk;
   pkt_req_s       req = '0;
   pkt_rsp_s       rsp;
   int             n_fail = 0, checks = 0, n, i;
   // ingress rows: received number, replay fail, stored sequence after
   logic [31:0]    ipn[4]  = '{32'h7, 32'h6, 32'h5, 32'h9};
   logic [31:0]    iseq[4] = '{32'h8, 32'h8, 32'h8, 32'ha};
   logic           ifl[4]  = '{1'b0, 1'b0, 1'b1, 1'b0};
   // free running 40 MHz clock
   always #12.5 clk = ~clk;
   macsec_sa_context_seq i_macsec_sa_context_seq (.CLK_IN(clk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(adr),
      .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hf),
      .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wq), .REQ_VALID_IN(vld), .REQ_IN(req),
      .REQ_READY_OUT(rdy), .RSP_VALID_OUT(rv), .RSP_OUT(rsp), .KEY_OUT(key), .HASH_KEY_OUT(hk));
   // record word address, word index times four
   function automatic logic [10:0] ra(input int s, input int w);
      return 11'h400 + 11'(s * 128 + w * 4);
   endfunction
   task automatic chk(input logic [255:0] g, input logic [255:0] e);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   // request held to the edge that samples waitrequest low; read data taken there
   task automatic bus(input logic w, input logic [10:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a; wd <= d; wr <= w; rd <= !w;
      @(posedge clk);
      while (wq !== 1'b0) @(posedge clk);
      q = rdat;
      rd <= 0; wr <= 0;
   endtask
   // n counts edges from the accept edge to the result pulse
   task automatic pkt(input logic [7:0] s, input logic [31:0] p);
      @(posedge clk);
      vld <= 1; req <= '{s, p};
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      vld <= 0; #1 n = 0;
      // engine busy: further requests refused until the result pulse
      chk(rdy, 1'b0);
      while (rv !== 1'b1) begin
         @(posedge clk); #1 n++;
      end
   endtask
   task automatic test_done;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // hang guard, far beyond the few hundred cycles needed
   initial begin
      #100us; n_fail++; test_done();
   end
   // ***********************
   // main sequence
   // ***********************
   initial begin
      repeat (3) @(posedge clk);
      rst <= 0;
      bus(0, REG_CTX_CTRL, 0);    chk(q, CTX_CTRL_RST);
      bus(0, REG_COUNT_LIMIT, 0); chk(q, COUNT_LIMIT_RST);
      bus(0, REG_IRQ_STAT, 0);    chk(q, 32'h0);
      bus(0, 11'h07c, 0);         chk(q, 32'h0);
      // sa0 egress aes-128, an 2; sa1 ingress, seq 1, window 2
      bus(1, ra(0, 0), 32'h9a4b_e066);
      bus(1, ra(1, 0), 32'hd24b_e06f);
      // key and hash words stand in for software-derived values
      for (i = 1; i < 14; i++) begin
         bus(1, ra(0, i), (i == 10) ? 32'h0 : 32'h0101_0101 * i);
         bus(1, ra(1, i), (i == 10) ? 32'h1 : (i == 11) ? 32'h2 : 32'h0101_0101 * i);
      end
      // flows enabled only once the sa0 and sa1 records are loaded
      bus(1, REG_FLOW_CTRL, 32'h1a);
      bus(1, REG_COUNT_LIMIT, 0);
      pkt(0, 0);
      chk(n, 21);
      chk(rsp.pn, 32'h1);
      chk(rsp.association_number, 2'h2);
      chk(rsp.sci, 64'h0c0c0c0c_0b0b0b0b);
      chk(key, {128'h0, 128'h05050505_04040404_03030303_02020202});
      chk(hk, 128'h09090909_08080808_07070707_06060606);
      bus(0, ra(0, 10), 0); chk(q, 32'h1);
      bus(0, ra(0, 0), 0);  chk(q, 32'h9a4b_e066);
      bus(0, REG_IRQ_STAT, 0); chk(q[5:4], 2'h1);
      bus(1, REG_IRQ_STAT, 32'h30);
      bus(0, REG_IRQ_STAT, 0); chk(q[5:4], 2'h0);
      bus(1, REG_CTX_CTRL, 32'h1);
      pkt(0, 0); chk(n, 25);
      chk(rsp.pn, 32'h2);
      // wrap is refused every time and the stored value never moves
      bus(1, ra(0, 10), 32'hffff_ffff);
      repeat (2) begin
         pkt(0, 0); chk(rsp.seq_err, 1'b1);
         bus(0, ra(0, 10), 0); chk(q, 32'hffff_ffff);
      end
      bus(0, REG_IRQ_STAT, 0); chk(q[5], 1'b1);
      for (i = 0; i < 4; i++) begin
         pkt(1, ipn[i]); chk(rsp.replay_fail, ifl[i]);
         bus(0, ra(1, 10), 0); chk(q, iseq[i]);
      end
      pkt(2, 0); chk(rsp.dropped, 1'b1);
      pkt(3, 0); chk(rsp.bypassed, 1'b1);
      // unknown type code: context refused, sequence word untouched
      bus(1, ra(0, 0), 32'h9a4b_e060);
      pkt(0, 0); chk(rsp.ctx_invalid, 1'b1);
      bus(0, ra(0, 10), 0); chk(q, 32'hffff_ffff);
      // reset in mid-run: registers and results return to reset values
      @(posedge clk);
      rst <= 1;
      @(posedge clk);
      rst <= 0;
      #1 chk(rdy, 1'b1);
      chk(rv, 1'b0);
      chk(rsp, '0);
      chk(key, '0);
      bus(0, REG_COUNT_LIMIT, 0); chk(q, COUNT_LIMIT_RST);
      test_done();
   end
endmodule
